// ===== hdl/dps_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

// register indices; byte address is four times the index
`define DPS_IDX_CLKCFG     8'h02
`define DPS_IDX_SYNCCFG    8'h05
`define DPS_IDX_LOCKSTAT   8'h12
`define DPS_IDX_INTERP     8'h20
`define DPS_IDX_SAMPLE     8'h21

// clock configuration fields
`define DPS_BIT_RECOVERY   2
`define DPS_BIT_CLKOUT     3
`define DPS_BIT_POLARITY   4
`define DPS_CLKCFG_MASK    8'h1C
`define DPS_CLKCFG_RST     8'h00

// sync configuration fields
`define DPS_BIT_MODSEL     3
`define DPS_OFFSET_LSB     4
`define DPS_OFFSET_MSB     7
`define DPS_SYNCCFG_MASK   8'hF8
`define DPS_SYNCCFG_RST    8'h00

// interpolation and lock status
`define DPS_INTERP_RST     2'h0
`define DPS_LOCK_LOST      0
`define DPS_LOCK_NOW       1
`define DPS_LOCK_EVER      2
`define DPS_LOCKSTAT_RST   3'h0

// converter clock is mclk divided by four
`define DPS_DIV_BITS       2
`define DPS_POS_W          5
`define DPS_SUB_HALF       2'h2

// timing
`define DPS_MCLK_PS        50000
`define DPS_TRANS_SETUP_PS 1500
`define DPS_TRANS_SETUP_CYC \
  ((`DPS_TRANS_SETUP_PS + `DPS_MCLK_PS - 1) / `DPS_MCLK_PS)
`define DPS_LOCK_EDGES     3'h4

`endif

// ===== hdl/dps_phase_gen.sv
// converter clock phase counter, wraps at interpolation factor
`timescale 1ns/1ps
`include "dps_map.svh"

module dps_phase_gen
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // phase port
  dps_phase_if.gen  ph
);

  logic [`DPS_POS_W-1:0] pos_reg;
  logic [`DPS_POS_W-1:0] pos_next;
  logic [`DPS_DIV_BITS-1:0] subNext;

  // wrap keeps the sub-cycle running, so a shorter period never cuts a clock
  assign subNext  = pos_reg[`DPS_DIV_BITS-1:0] + `DPS_DIV_BITS'(1);
  assign pos_next = ph.load ? ph.loadPos :
                    (pos_reg >= ph.periodLast) ? `DPS_POS_W'(subNext) :
                    pos_reg + `DPS_POS_W'(1);
  assign ph.pos   = pos_reg;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      pos_reg <= '0;
    else
      pos_reg <= pos_next;
  end

endmodule

// ===== hdl/dps_phase_if.sv
// converter phase counter signals between top and phase generator
`timescale 1ns/1ps
`include "dps_map.svh"

interface dps_phase_if;
  logic [`DPS_POS_W-1:0] periodLast;
  logic                  load;
  logic [`DPS_POS_W-1:0] loadPos;
  logic [`DPS_POS_W-1:0] pos;

  modport gen
  (
    input  periodLast,
    input  load,
    input  loadPos,
    output pos
  );

  modport user
  (
    output periodLast,
    output load,
    output loadPos,
    input  pos
  );
endinterface

// ===== hdl/dps_pkg.sv
// types shared by the data port clock sync block
package dps_pkg;

  typedef enum {
    DPS_MASTER,
    DPS_MOD_MASTER,
    DPS_EXT_SYNC,
    DPS_SLAVE,
    DPS_LOW_SETUP_HOLD,
    DPS_MOD_SLAVE
  } dps_mode_t;

  typedef enum logic [1:0] {
    DPS_X1,
    DPS_X2,
    DPS_X4,
    DPS_X8
  } dps_interp_t;

  typedef logic [15:0] dps_sample_t;

endpackage

// ===== hdl/dps_port_top.sv
// sample input port with data-rate clock modes and latch edge selection
// How it works
// [RQ1] clock-output enable drives data-rate pin: data rate, or modulator sync
// [RQ2] all three select bits low: external sync, converter clock times data
// [RQ3] output off, recovery on: slave, or modulator slave with sync select
// [RQ4] output off, sync select 1, recovery off: low setup/hold mode
// [RQ5] master 1x: data-rate clock is inverted, delayed converter clock copy
// [RQ6] 1x: polarity 0 latches on falling edge, 1 on rising edge
// [RQ7] 2x: every second rising edge, before data-rate fall or rise
// [RQ8] 4x and 8x: every fourth or eighth rising edge, same polarity choice
// [RQ9] generated data-rate clock high phase is slightly under half period
// [RQ10] far party supplies converter clock and data-rate clock in slave; converter clock is still driven here from the phase counter
// [RQ11] slave aligns phase counter to incoming clock; polarity picks edge
// [RQ12] slave polarity 0: last rising edge at least setup before fall
// [RQ13] far party keeps converter edges out of the keep-out window
// [RQ14] three lock status bits readable at bits 0 to 2
// [RQ15] bit 2 ever locked, bit 1 locked now, bit 0 lost lock
// [RQ16] low setup/hold latches on data-rate clock edge chosen by polarity
// [RQ17] external sync keeps pin an input and ignores it
// [RQ18] external sync 1x latches every cycle like master, no clock out
// [RQ19] external sync: polarity toggle shifts latch by half the factor
// [RQ20] external sync ignores the latch edge offset
// [RQ21] operator toggles polarity on noise floor degradation
// [RQ22] latch strobe comes from phase counter wrapping at interpolation factor; low setup/hold mode uses data-rate clock edges instead
`timescale 1ns/1ps
`include "dps_map.svh"

module dps_port_top
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               resetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [31:0]        hrdata,
  // sample port
  input  wire dps_pkg::dps_sample_t sampleIn,
  output dps_pkg::dps_sample_t    sampleOut,
  output logic                    sampleValid,
  // data-rate clock pin
  input  wire logic               dataRateClkIn,
  output logic                    dataRateClkOut,
  output logic                    dataRateClkOe,
  // converter clock and modulator sync
  output logic                    converterClkOut,
  input  wire logic               modSyncIn,
  output logic                    modSyncOut
);

  import dps_pkg::*;

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic [7:0]            clkCfg_reg;
  logic [7:0]            syncCfg_reg;
  dps_interp_t           interp_reg;
  logic [2:0]            lockStat_reg;
  logic [2:0]            lockCnt_reg;
  logic                  wrPend_reg;
  logic [7:0]            wrIdx_reg;
  logic [31:0]           hrdata_reg;
  dps_sample_t           sample_reg;
  logic                  sampleValid_reg;
  logic                  dclkPrev_reg;
  logic                  dclkOut_reg;
  logic                  dclkOe_reg;
  logic                  convClk_reg;
  logic                  modulator_sync_select_reg;

  // --------------------------------------------------------------
  // synchronisers and phase counter
  // --------------------------------------------------------------
  logic                  dclkSync;
  dps_sample_t           sampleSync;
  dps_phase_if           ph ();

  dps_sync2 #(.WIDTH(1)) u_dclkSync
  (
    .mclk   (mclk),
    .resetn (resetn),
    .d      (dataRateClkIn),
    .q      (dclkSync)
  );

  dps_sync2 #(.WIDTH($bits(dps_sample_t))) u_sampleSync
  (
    .mclk   (mclk),
    .resetn (resetn),
    .d      (sampleIn),
    .q      (sampleSync)
  );

  dps_phase_gen u_phase
  (
    .mclk   (mclk),
    .resetn (resetn),
    .ph     (ph.gen)
  );

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  wire        addrPhase = hsel & hready & htrans[1];
  wire        inRange   = (haddr[31:10] == 22'h000000);
  wire [7:0]  accIdx    = haddr[9:2];
  wire        wrClk     = wrPend_reg & (wrIdx_reg == `DPS_IDX_CLKCFG);
  wire        wrSync    = wrPend_reg & (wrIdx_reg == `DPS_IDX_SYNCCFG);
  wire        wrLock    = wrPend_reg & (wrIdx_reg == `DPS_IDX_LOCKSTAT);
  wire        wrInterp  = wrPend_reg & (wrIdx_reg == `DPS_IDX_INTERP);
  wire [31:0] rdValue   =
    !inRange                        ? 32'h00000000 :
    (accIdx == `DPS_IDX_CLKCFG)     ? {24'h000000, clkCfg_reg} :
    (accIdx == `DPS_IDX_SYNCCFG)    ? {24'h000000, syncCfg_reg} :
    (accIdx == `DPS_IDX_LOCKSTAT)   ? {29'h00000000, lockStat_reg} : // RQ14
    (accIdx == `DPS_IDX_INTERP)     ? {30'h00000000, interp_reg} :
    (accIdx == `DPS_IDX_SAMPLE)     ? {16'h0000, sample_reg} :
    32'h00000000;

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // --------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------
  wire        clkOutEn = clkCfg_reg[`DPS_BIT_CLKOUT];
  wire        recEn    = clkCfg_reg[`DPS_BIT_RECOVERY];
  wire        pol      = clkCfg_reg[`DPS_BIT_POLARITY];
  wire        modSel   = syncCfg_reg[`DPS_BIT_MODSEL];
  dps_mode_t  mode;

  assign mode = clkOutEn ? (modSel ? DPS_MOD_MASTER : DPS_MASTER) :        // RQ1
                recEn    ? (modSel ? DPS_MOD_SLAVE : DPS_SLAVE) :         // RQ3
                modSel   ? DPS_LOW_SETUP_HOLD :                           // RQ4
                DPS_EXT_SYNC;                                             // RQ2

  wire slaveMode  = (mode == DPS_SLAVE) | (mode == DPS_MOD_SLAVE);
  wire masterMode = (mode == DPS_MASTER) | (mode == DPS_MOD_MASTER);
  wire useOffset  = slaveMode | masterMode;                               // RQ20

  // --------------------------------------------------------------
  // phase geometry
  // --------------------------------------------------------------
  wire [2:0] factorLast =
    (interp_reg == DPS_X1) ? 3'h0 :
    (interp_reg == DPS_X2) ? 3'h1 :
    (interp_reg == DPS_X4) ? 3'h3 : 3'h7;                                 // RQ22

  wire [`DPS_DIV_BITS-1:0]  sub   = ph.pos[`DPS_DIV_BITS-1:0];
  wire [2:0]                phase = ph.pos[`DPS_POS_W-1:`DPS_DIV_BITS];
  wire                      convRise = (sub == '0);
  wire                      convFall = (sub == `DPS_SUB_HALF);

  assign ph.periodLast = {factorLast, {`DPS_DIV_BITS{1'b1}}};

  wire [`DPS_POS_W:0] periodCnt = {1'b0, ph.periodLast} + (`DPS_POS_W+1)'(1);
  wire [`DPS_POS_W:0] halfPos   = periodCnt >> 1;
  wire [`DPS_POS_W:0] setupPos  =
    halfPos - (`DPS_POS_W+1)'(`DPS_TRANS_SETUP_CYC);
  wire [`DPS_POS_W:0] riseStart =
    periodCnt - (`DPS_POS_W+1)'(`DPS_SUB_HALF) + (`DPS_POS_W+1)'(1);
  wire [`DPS_POS_W:0] fallStop  = halfPos - (`DPS_POS_W+1)'(`DPS_SUB_HALF);

  // --------------------------------------------------------------
  // latch edge offset, scaled to the interpolation factor
  // --------------------------------------------------------------
  wire signed [3:0] offRaw   = syncCfg_reg[`DPS_OFFSET_MSB:`DPS_OFFSET_LSB];
  wire        [1:0] offShift =
    (interp_reg == DPS_X8) ? 2'h0 :
    (interp_reg == DPS_X4) ? 2'h1 : 2'h2;
  wire signed [3:0] offScaled = offRaw >>> offShift;
  wire        [2:0] offEff    = useOffset ? (offScaled[2:0] & factorLast) : 3'h0;

  // --------------------------------------------------------------
  // latch phase selection
  // --------------------------------------------------------------
  wire [2:0] slavePhase = setupPos[`DPS_POS_W-1:`DPS_DIV_BITS];          // RQ12
  wire [2:0] basePhase  =
    pol       ? factorLast :                                              // RQ7
    slaveMode ? slavePhase :                                              // RQ11
    (factorLast >> 1);                                                    // RQ8
  wire [2:0] latchPhase = (basePhase + offEff) & factorLast;             // RQ19

  wire phaseStrobe =
    (interp_reg == DPS_X1) ? (pol ? convRise : convFall) :                // RQ6 RQ18
    (convRise & (phase == latchPhase));                                   // RQ22

  // --------------------------------------------------------------
  // incoming data-rate clock edges
  // --------------------------------------------------------------
  wire riseDet = dclkSync & ~dclkPrev_reg;
  wire fallDet = ~dclkSync & dclkPrev_reg;

  wire latchStrobe =
    (mode == DPS_LOW_SETUP_HOLD) ? (pol ? riseDet : fallDet) :            // RQ16
    phaseStrobe;

  // --------------------------------------------------------------
  // slave alignment and lock tracking
  // --------------------------------------------------------------
  wire slaveEdge = slaveMode & riseDet;                                   // RQ10
  wire goodEdge  = slaveEdge & (phase == 3'h0);
  wire badEdge   = slaveEdge & (phase != 3'h0);
  wire locked    = (lockCnt_reg == `DPS_LOCK_EDGES);

  // edge cycle becomes phase zero; sub-cycle kept so converter clock runs on
  assign ph.load    = badEdge;                                            // RQ11
  assign ph.loadPos = `DPS_POS_W'(sub) + `DPS_POS_W'(1);

  wire [2:0] lockCnt_next =
    !slaveMode ? 3'h0 :
    badEdge    ? 3'h0 :
    (goodEdge & !locked) ? lockCnt_reg + 3'h1 :
    lockCnt_reg;

  // sticky bits: hardware set wins over write-one clear
  wire lostSet  = badEdge & locked;
  wire everSet  = slaveMode & locked;
  wire lostClr  = wrLock & hwdata[`DPS_LOCK_LOST];
  wire everClr  = wrLock & hwdata[`DPS_LOCK_EVER];
  wire [2:0] lockStat_next;

  assign lockStat_next[`DPS_LOCK_LOST] =
    lostSet | (recEn & lockStat_reg[`DPS_LOCK_LOST] & ~lostClr);          // RQ15
  assign lockStat_next[`DPS_LOCK_NOW]  = slaveMode & locked;              // RQ15
  assign lockStat_next[`DPS_LOCK_EVER] =
    everSet | (recEn & lockStat_reg[`DPS_LOCK_EVER] & ~everClr);          // RQ15

  // --------------------------------------------------------------
  // generated data-rate clock
  // --------------------------------------------------------------
  wire [2:0]             relPhase = (phase - offEff) & factorLast;
  wire [`DPS_POS_W:0]    relPos   = {1'b0, relPhase, sub};
  wire dclkHigh = (relPos >= riseStart) | (relPos < fallStop);            // RQ5 RQ9
  wire dclkOut_next =
    !clkOutEn ? 1'b0 :                                                    // RQ17
    modSel    ? modSyncIn : dclkHigh;                                     // RQ1

  // --------------------------------------------------------------
  // bus registers
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPend_reg <= 1'b0;
      wrIdx_reg  <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end
    else
    begin
      wrPend_reg <= addrPhase & hwrite & inRange;
      wrIdx_reg  <= accIdx;
      if (addrPhase & !hwrite)
        hrdata_reg <= rdValue;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      clkCfg_reg  <= `DPS_CLKCFG_RST;
      syncCfg_reg <= `DPS_SYNCCFG_RST;
      interp_reg  <= dps_interp_t'(`DPS_INTERP_RST);
    end
    else
    begin
      if (wrClk)
        clkCfg_reg <= hwdata[7:0] & `DPS_CLKCFG_MASK;
      if (wrSync)
        syncCfg_reg <= hwdata[7:0] & `DPS_SYNCCFG_MASK;
      if (wrInterp)
        interp_reg <= dps_interp_t'(hwdata[1:0]);
    end
  end

  // --------------------------------------------------------------
  // lock state
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      lockCnt_reg  <= 3'h0;
      lockStat_reg <= `DPS_LOCKSTAT_RST;
    end
    else
    begin
      lockCnt_reg  <= lockCnt_next;
      lockStat_reg <= lockStat_next;
    end
  end

  // --------------------------------------------------------------
  // sample capture
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sample_reg      <= '0;
      sampleValid_reg <= 1'b0;
    end
    else
    begin
      sampleValid_reg <= latchStrobe;
      if (latchStrobe)
        sample_reg <= sampleSync;
    end
  end

  assign sampleOut   = sample_reg;
  assign sampleValid = sampleValid_reg;

  // --------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dclkPrev_reg <= 1'b0;
      dclkOut_reg  <= 1'b0;
      dclkOe_reg   <= 1'b0;
      convClk_reg  <= 1'b0;
      modulator_sync_select_reg  <= 1'b0;
    end
    else
    begin
      dclkPrev_reg <= dclkSync;
      dclkOut_reg  <= dclkOut_next;
      dclkOe_reg   <= clkOutEn;                                           // RQ1
      convClk_reg  <= (sub < `DPS_SUB_HALF);
      modulator_sync_select_reg  <= (mode == DPS_MOD_SLAVE) & riseDet;
    end
  end

  assign dataRateClkOut  = dclkOut_reg;
  assign dataRateClkOe   = dclkOe_reg;
  assign converterClkOut = convClk_reg;
  assign modSyncOut      = modulator_sync_select_reg;

endmodule

// ===== hdl/dps_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module dps_sync2
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ===== verif/dps_data_source.sv
// far-side data engine: sample word and data-rate clock
`timescale 1ns/1ps

module dps_data_source
(
  // control from bench
  input  wire logic                 run,
  input  wire logic                 jump,
  input  wire dps_pkg::dps_sample_t word,
  // pins
  output logic                      linkClk,
  output dps_pkg::dps_sample_t      sampleIn
);
  import dps_pkg::*;
  logic late = 1'b0;

  assign sampleIn = word;

  // one commanded phase slip
  always @(posedge jump)
    late = 1'b1;

  // 400 ns clock, unrelated phase, still while idle
  initial
  begin
    linkClk = 1'b0;
    #37;
    forever
    begin
      #200;
      if (late)
      begin
        #200;
        late = 1'b0;
      end
      if (run)
        linkClk = ~linkClk;
    end
  end
endmodule

// ===== verif/dps_port_top_sva.sv
// port assertions for the data port clock sync block
`timescale 1ns/1ps
`include "dps_map.svh"

module dps_port_top_sva
(
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 resetn,
  // register bus
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [31:0]          hrdata,
  // sample port and clocks
  input wire dps_pkg::dps_sample_t sampleOut,
  input wire logic                 sampleValid,
  input wire logic                 converterClkOut,
  input wire logic                 modSyncOut
);
  import dps_pkg::*;
  localparam logic [31:0] SMP_ADDR = {22'h0, `DPS_IDX_SAMPLE, 2'h0};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire rdReq = hsel && hready && htrans[1] && !hwrite;

  sequence s_convHigh; converterClkOut [*2]; endsequence
  sequence s_convLow; !converterClkOut [*2] ##1 converterClkOut; endsequence

  property p_ready; hreadyout; endproperty
  property p_okay; !hresp; endproperty
  property p_validPulse; sampleValid |=> !sampleValid; endproperty
  property p_sampleHold; $changed(sampleOut) |-> sampleValid; endproperty
  property p_convClk; $rose(converterClkOut) |-> s_convHigh ##1 s_convLow; endproperty
  property p_modPulse; modSyncOut |=> !modSyncOut; endproperty
  property p_rdSample;
    rdReq && haddr == SMP_ADDR |=> hrdata == {16'h0, $past(sampleOut)}
      || hrdata == {16'h0, $past(sampleOut, 2)};
  endproperty
  property p_rdUnmapped; rdReq && haddr[9:2] == 8'hFF |=> hrdata == 32'h0; endproperty

  a_ready: assert property (p_ready)
    else $error("hreadyout low");
  a_okay: assert property (p_okay)
    else $error("hresp not okay");
  a_validPulse: assert property (p_validPulse)
    else $error("sampleValid longer than one cycle");
  a_sampleHold: assert property (p_sampleHold)
    else $error("sampleOut changed without sampleValid");
  a_convClk: assert property (p_convClk)
    else $error("converter clock not two high two low");
  a_modPulse: assert property (p_modPulse)
    else $error("modSyncOut longer than one cycle");
  a_rdSample: assert property (p_rdSample)
    else $error("sample register read wrong");
  a_rdUnmapped: assert property (p_rdUnmapped)
    else $error("unmapped read not zero");
endmodule

bind dps_port_top dps_port_top_sva dps_port_top_sva_i (.*);

// ===== verif/dps_port_top_tb.sv
// self-checking bench for the data port clock sync block
`timescale 1ns/1ps
`include "dps_map.svh"

module dps_port_top_tb;
  import dps_pkg::*;
  localparam logic [31:0] aClk = {22'h0, `DPS_IDX_CLKCFG, 2'h0};
  localparam logic [31:0] aSyn = {22'h0, `DPS_IDX_SYNCCFG, 2'h0};
  localparam logic [31:0] aLck = {22'h0, `DPS_IDX_LOCKSTAT, 2'h0};
  localparam logic [31:0] aInt = {22'h0, `DPS_IDX_INTERP, 2'h0};
  localparam logic [31:0] aSmp = {22'h0, `DPS_IDX_SAMPLE, 2'h0};
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        sampleValid;
  logic        dataRateClkOut;
  logic        dataRateClkOe;
  logic        converterClkOut;
  logic        modSyncOut;
  logic        modSyncIn = 1'b0;
  logic        run = 1'b0;
  logic        jump = 1'b0;
  logic        linkClk;
  logic        convPrev = 1'b0;
  logic [1:0]  edgeSeen;
  dps_sample_t word = 16'h0;
  dps_sample_t sampleIn;
  dps_sample_t sampleOut;
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;
  wire         pinLevel = dataRateClkOe ? dataRateClkOut : linkClk;

  dps_port_top dps_port_top_i
  (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .sampleIn(sampleIn),
    .sampleOut(sampleOut), .sampleValid(sampleValid), .dataRateClkIn(pinLevel),
    .dataRateClkOut(dataRateClkOut), .dataRateClkOe(dataRateClkOe),
    .converterClkOut(converterClkOut), .modSyncIn(modSyncIn), .modSyncOut(modSyncOut)
  );

  dps_data_source dps_data_source_i
  (
    .run(run), .jump(jump), .word(word), .linkClk(linkClk), .sampleIn(sampleIn)
  );

  always #25 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    convPrev <= converterClkOut;
    if (cyc == 20000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chkW(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkN(input int got, input int exp);
    checks++;
    if (got != exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one bus phase, held until hready seen high
  task automatic rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1)
      fails++;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chkW(rd, exp);
  endtask

  // third strobe after a change, its interval checked
  task automatic valid3(output int t, input int per);
    int t0;
    for (int k = 0; k < 3; k++)
    begin
      t0 = t;
      do
        @(posedge mclk);
      while (sampleValid !== 1'b1 && cyc < 20000);
      t = cyc;
      edgeSeen = {converterClkOut, convPrev};
    end
    chkN(t - t0, per);
  endtask

  task automatic lvl(input logic v);
    do
      @(posedge mclk);
    while (dataRateClkOut !== v && cyc < 20000);
  endtask

  task automatic measClk(output int hi, output int per);
    int t0;
    lvl(1'b0);
    lvl(1'b1);
    t0 = cyc;
    lvl(1'b0);
    hi = cyc - t0;
    lvl(1'b1);
    per = cyc - t0;
  endtask

  task automatic t_regs;
    rdChk(aClk, 32'h0);
    rdChk(aSyn, 32'h0);
    rdChk(aLck, 32'h0);
    rdChk(aInt, 32'h0);
    wr(32'h3FC, 32'hFFFFFFFF);
    rdChk(32'h3FC, 32'h0);
    wr(aSyn, 32'hFF);
    rdChk(aSyn, 32'hF8);
    wr(aInt, 32'hFF);
    rdChk(aInt, 32'h3);
    wr(aSmp, 32'hFFFF);
    rdChk(aSmp, 32'h0);
    wr(aSyn, 32'h0);
  endtask

  task automatic t_ext;
    int a;
    int b;
    int c;
    int f;
    run <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      f = 4 << i;
      word <= 16'hA5C0 + 16'(i);
      wr(aInt, 32'(i));
      wr(aClk, 32'h0);
      wr(aSyn, 32'h0);
      valid3(a, f);
      if (i == 0) chkW(32'(edgeSeen), 32'h1);
      chkW({16'h0, sampleOut}, {16'h0, word});
      rdChk(aSmp, {16'h0, word});
      wr(aClk, 32'h10);
      valid3(b, f);
      if (i == 0) chkW(32'(edgeSeen), 32'h2);
      chkN((b - a) % f, f / 2);
      wr(aSyn, 32'h70);
      valid3(c, f);
      chkN((c - b) % f, 0);
      chkW({31'h0, dataRateClkOe}, 32'h0);
    end
  endtask

  task automatic t_master;
    int hi;
    int per;
    wr(aSyn, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(aInt, 32'(i));
      wr(aClk, 32'h08);
      measClk(hi, per);
      measClk(hi, per);
      chkN(per, 4 << i);
      chkN(hi, (2 << i) - 1);
      chkW({31'h0, dataRateClkOe}, 32'h1);
    end
    wr(aSyn, 32'h08);
    modSyncIn <= 1'b1;
    tick(3);
    chkW({31'h0, dataRateClkOut}, 32'h1);
    modSyncIn <= 1'b0;
    tick(3);
    chkW({31'h0, dataRateClkOut}, 32'h0);
  endtask

  task automatic t_slave;
    int a;
    int n;
    wr(aClk, 32'h0);
    wr(aSyn, 32'h0);
    wr(aInt, 32'h1);
    wr(aClk, 32'h04);
    tick(120);
    rdChk(aLck, 32'h6);
    valid3(a, 8);
    jump <= 1'b1;
    tick(1);
    jump <= 1'b0;
    tick(120);
    rdChk(aLck, 32'h7);
    wr(aLck, 32'h1);
    rdChk(aLck, 32'h6);
    wr(aSyn, 32'h08);
    tick(16);
    n = 0;
    repeat (80)
    begin
      @(posedge mclk);
      if (modSyncOut === 1'b1) n++;
    end
    chkN(n, 10);
    wr(aClk, 32'h0);
    tick(1);
    rdChk(aLck, 32'h0);
    valid3(a, 8);
    wr(aClk, 32'h10);
    valid3(a, 8);
    chkW({31'h0, dataRateClkOe}, 32'h0);
  endtask

  initial
  begin
    tick(2);
    resetn <= 1'b1;
    t_regs();
    t_ext();
    t_master();
    t_slave();
    summarize();
  end
endmodule
